// ==== hdl/plut_regs.svh ====
// Register indices, field positions, reset values and bus answers
`ifndef PLUT_REGS_SVH
`define PLUT_REGS_SVH

// Register indices; the byte address is four times the index
`define PLUT_IDX_DEPTH   8'h14
`define PLUT_IDX_INDEX   8'h15
`define PLUT_IDX_BANK    8'h16
`define PLUT_IDX_DATA    8'h17

// Bank select field positions (two bits each)
`define PLUT_BANK_RED    4
`define PLUT_BANK_GREEN  2
`define PLUT_BANK_BLUE   0

// Table index fields
`define PLUT_INDEX_COL   4
`define PLUT_NUM_COL     2'h3

// Reset values
`define PLUT_DEPTH_RST   2'h0
`define PLUT_INDEX_RST   6'h00
`define PLUT_BANK_RST    6'h00
`define PLUT_ENTRY_RST   4'h0

// AXI4-Lite responses
`define PLUT_RESP_OKAY   2'h0
`define PLUT_RESP_SLVERR 2'h2

`endif

// ==== hdl/plut_pkg.sv ====
// Types shared by the palette table bank and its translators
package plut_pkg;

    // Colour depth codes held in the depth register
    typedef enum logic [1:0] {
        PLUT_BPP1 = 2'h0,
        PLUT_BPP2 = 2'h1,
        PLUT_BPP4 = 2'h2,
        PLUT_BPP8 = 2'h3
    } plut_depth_t;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        PLUT_SEL_NONE  = 3'h0,
        PLUT_SEL_DEPTH = 3'h1,
        PLUT_SEL_INDEX = 3'h2,
        PLUT_SEL_BANK  = 3'h3,
        PLUT_SEL_DATA  = 3'h4
    } plut_sel_t;

    // Bus channel states, one-hot
    typedef enum logic [1:0] {
        PLUT_ST_IDLE = 2'b01,
        PLUT_ST_RESP = 2'b10
    } plut_state_t;

endpackage

// ==== hdl/plut_xlate.sv ====
// One colour's pixel translation through its table with bank selection
`timescale 1ns/1ps
`include "plut_regs.svh"

module plut_xlate
    import plut_pkg::*;
#(
    parameter logic WIDE8 = 1'b1
)
(
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire plut_depth_t       depth_i,
    input  wire logic [1:0]        bank_i,
    input  wire logic [7:0]        pixel_i,
    input  wire logic [2:0]        field8_i,
    input  wire logic [15:0][3:0]  tbl_i,
    output logic      [3:0]        out_o
);

    logic [3:0] idx;
    logic [3:0] out_q;

    // Table position from depth, bank bits and pixel bits
    always_comb
    begin
        case (depth_i)
            PLUT_BPP1: idx = {1'b0, bank_i, pixel_i[0]};
            PLUT_BPP2: idx = {bank_i, pixel_i[1:0]};
            PLUT_BPP4: idx = pixel_i[3:0];
            PLUT_BPP8:
            begin
                // Red and green keep one bank bit; blue keeps two
                if (WIDE8)
                    idx = {bank_i[0], field8_i};
                else
                    idx = {bank_i, field8_i[1:0]};
            end
            default:   idx = pixel_i[3:0];
        endcase
    end

    // Registered so the colour outputs come from flops
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            out_q <= `PLUT_ENTRY_RST;
        else
            out_q <= tbl_i[idx];
    end

    assign out_o = out_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_one_bpp_low: assert property (
        depth_i == PLUT_BPP1
        |=> out_q == $past(tbl_i[{1'b0, bank_i, pixel_i[0]}]))
        else $error("1 bpp output not from the banked low eight");
    a_two_bpp_bank: assert property (
        depth_i == PLUT_BPP2
        |=> out_q == $past(tbl_i[{bank_i, pixel_i[1:0]}]))
        else $error("2 bpp output not from the selected bank");
    a_four_bpp_direct: assert property (
        depth_i == PLUT_BPP4 |=> out_q == $past(tbl_i[pixel_i[3:0]]))
        else $error("4 bpp output not the direct table entry");
    a_eight_bpp_half: assert property (
        depth_i == PLUT_BPP8 && WIDE8
        |=> out_q == $past(tbl_i[{bank_i[0], field8_i}]))
        else $error("8 bpp half not chosen by bank bit 0");
    c_one_bpp_high_bank: cover property (
        depth_i == PLUT_BPP1 && bank_i == 2'h3);

endmodule

// ==== hdl/plut_bank_regs.sv ====
// Palette table bank: AXI4-Lite registers, three colour tables, translation
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "plut_regs.svh"

module plut_bank_regs
    import plut_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [7:0]  pixel_i,
    output logic [3:0]       red_o,
    output logic [3:0]       green_o,
    output logic [3:0]       blue_o
);

    // Address decode shared by the write and read channels
    function automatic plut_sel_t plut_decode(input logic [7:0] addr);
        logic [7:0] word;
        begin
            word = {2'b00, addr[7:2]};
            case (word)
                `PLUT_IDX_DEPTH: plut_decode = PLUT_SEL_DEPTH;
                `PLUT_IDX_INDEX: plut_decode = PLUT_SEL_INDEX;
                `PLUT_IDX_BANK:  plut_decode = PLUT_SEL_BANK;
                `PLUT_IDX_DATA:  plut_decode = PLUT_SEL_DATA;
                default:         plut_decode = PLUT_SEL_NONE;
            endcase
        end
    endfunction

    plut_state_t             wstate_q;
    plut_state_t             rstate_q;
    logic                    awready_q;
    logic                    wready_q;
    logic                    aw_full_q;
    logic                    w_full_q;
    logic [7:0]              awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    logic                    arready_q;
    logic                    rvalid_q;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;
    plut_depth_t             depth_q;
    logic [5:0]              index_q;
    logic [5:0]              bank_q;
    logic [2:0][15:0][3:0]   tbl_q;
    logic [2:0][3:0]         colour;
    logic [2:0][2:0]         field8;

    logic                    aw_hs;
    logic                    w_hs;
    logic                    ar_hs;
    logic                    wr_fire;
    plut_sel_t               wsel;
    plut_sel_t               rsel;
    logic [1:0]              col;
    logic [3:0]              ent;
    logic [7:0]              rd_byte;

    assign aw_hs   = s_axi_awvalid_i & awready_q;
    assign w_hs    = s_axi_wvalid_i & wready_q;
    assign ar_hs   = s_axi_arvalid_i & arready_q;
    assign wr_fire = aw_full_q & w_full_q & (wstate_q == PLUT_ST_IDLE);
    assign wsel    = plut_decode(awaddr_q);
    assign rsel    = plut_decode(s_axi_araddr_i);
    // Colour and entry reached through the data window
    assign col     = index_q[`PLUT_INDEX_COL +: 2];
    assign ent     = index_q[3:0];

    // Write address is held until the pair fires
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 8'h00;
            awready_q <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_full_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_i;
            end
            else if (wr_fire)
                aw_full_q <= 1'b0;
            awready_q <= !aw_hs && !aw_full_q && (wstate_q == PLUT_ST_IDLE);
        end
    end

    // Write data is held the same way; either may arrive first
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            wready_q <= 1'b0;
        end
        else
        begin
            if (w_hs)
            begin
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata_i;
                wstrb_q  <= s_axi_wstrb_i;
            end
            else if (wr_fire)
                w_full_q <= 1'b0;
            wready_q <= !w_hs && !w_full_q && (wstate_q == PLUT_ST_IDLE);
        end
    end

    // Write response channel
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            wstate_q <= PLUT_ST_IDLE;
            bvalid_q <= 1'b0;
            bresp_q  <= `PLUT_RESP_OKAY;
        end
        else
        begin
            case (wstate_q)
                PLUT_ST_IDLE:
                begin
                    if (wr_fire)
                    begin
                        wstate_q <= PLUT_ST_RESP;
                        bvalid_q <= 1'b1;
                        bresp_q  <= (wsel == PLUT_SEL_NONE) ?
                                    `PLUT_RESP_SLVERR : `PLUT_RESP_OKAY;
                    end
                end
                PLUT_ST_RESP:
                begin
                    if (s_axi_bready_i)
                    begin
                        wstate_q <= PLUT_ST_IDLE;
                        bvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    wstate_q <= PLUT_ST_IDLE;
                    bvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // Control registers; only byte lane 0 carries them
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            depth_q <= plut_depth_t'(`PLUT_DEPTH_RST);
            index_q <= `PLUT_INDEX_RST;
            bank_q  <= `PLUT_BANK_RST;
        end
        else if (wr_fire && wstrb_q[0])
        begin
            case (wsel)
                PLUT_SEL_DEPTH: depth_q <= plut_depth_t'(wdata_q[1:0]);
                PLUT_SEL_INDEX: index_q <= wdata_q[5:0];
                PLUT_SEL_BANK:  bank_q  <= wdata_q[5:0];
                default:        ;
            endcase
        end
    end

    // Table entries written through the window; upper bits dropped
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            tbl_q <= '0;
        else if (wr_fire && wstrb_q[0] && wsel == PLUT_SEL_DATA
                 && col < `PLUT_NUM_COL)
            tbl_q[col][ent] <= wdata_q[3:0];
    end

    // Read byte; the window shows the indexed entry, not a stored value
    always_comb
    begin
        case (rsel)
            PLUT_SEL_DEPTH: rd_byte = {6'h00, depth_q};
            PLUT_SEL_INDEX: rd_byte = {2'h0, index_q};
            PLUT_SEL_BANK:  rd_byte = {2'h0, bank_q};
            PLUT_SEL_DATA:
            begin
                // Colour code 3 has no table and reads zero
                if (col < `PLUT_NUM_COL)
                    rd_byte = {4'h0, tbl_q[col][ent]};
                else
                    rd_byte = 8'h00;
            end
            default:        rd_byte = 8'h00;
        endcase
    end

    // Read channel; one read in flight, a bubble before the next
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            rstate_q  <= PLUT_ST_IDLE;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `PLUT_RESP_OKAY;
        end
        else
        begin
            arready_q <= !ar_hs && (rstate_q == PLUT_ST_IDLE);
            case (rstate_q)
                PLUT_ST_IDLE:
                begin
                    if (ar_hs)
                    begin
                        rstate_q <= PLUT_ST_RESP;
                        rvalid_q <= 1'b1;
                        rdata_q  <= {24'h00_0000, rd_byte};
                        rresp_q  <= (rsel == PLUT_SEL_NONE) ?
                                    `PLUT_RESP_SLVERR : `PLUT_RESP_OKAY;
                    end
                end
                PLUT_ST_RESP:
                begin
                    if (s_axi_rready_i)
                    begin
                        rstate_q <= PLUT_ST_IDLE;
                        rvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    rstate_q <= PLUT_ST_IDLE;
                    rvalid_q <= 1'b0;
                end
            endcase
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    // 8 bpp pixel fields: red 7:5, green 4:2, blue 1:0
    assign field8[0] = pixel_i[7:5];
    assign field8[1] = pixel_i[4:2];
    assign field8[2] = {1'b0, pixel_i[1:0]};

    // One translator per colour; red bank bits sit highest
    genvar c;
    generate
        for (c = 0; c < 3; c++)
        begin : g_colour
            plut_xlate #(
                .WIDE8    (c != 2)
            ) u_xlate (
                .mclk_i   (mclk_i),
                .rst_b_i  (rst_b_i),
                .depth_i  (depth_q),
                .bank_i   (bank_q[(2 - c) * 2 +: 2]),
                .pixel_i  (pixel_i),
                .field8_i (field8[c]),
                .tbl_i    (tbl_q[c]),
                .out_o    (colour[c])
            );
        end
    endgenerate

    assign red_o   = colour[0];
    assign green_o = colour[1];
    assign blue_o  = colour[2];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_window_read: assert property (
        ar_hs && rsel == PLUT_SEL_DATA && col < `PLUT_NUM_COL
        |=> s_axi_rvalid_o && s_axi_rdata_o[3:0] == $past(tbl_q[col][ent]))
        else $error("window read did not return the indexed entry");
    a_window_upper: assert property (
        ar_hs && rsel == PLUT_SEL_DATA |=> s_axi_rdata_o[31:4] == 28'h0)
        else $error("upper window bits not zero");
    a_window_write: assert property (
        wr_fire && wstrb_q[0] && wsel == PLUT_SEL_DATA && col < `PLUT_NUM_COL
        |=> tbl_q[$past(col)][$past(ent)] == $past(wdata_q[3:0]))
        else $error("window write did not reach the table");
    a_write_answer: assert property (
        aw_hs && w_hs ##1 !aw_hs |-> ##1 s_axi_bvalid_o)
        else $error("write answer not given two cycles after the pair");
    a_read_hold: assert property (
        s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped before it was taken");

    c_window_write: cover property (wr_fire && wsel == PLUT_SEL_DATA);
    c_window_read: cover property (ar_hs && rsel == PLUT_SEL_DATA);
    c_unmapped_read: cover property (ar_hs && rsel == PLUT_SEL_NONE);

endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the palette table bank over AXI4-Lite
`timescale 1ns/1ps
`include "plut_regs.svh"

module tb_top;

    localparam logic [7:0] A_DEP = `PLUT_IDX_DEPTH << 2;
    localparam logic [7:0] A_IDX = `PLUT_IDX_INDEX << 2;
    localparam logic [7:0] A_BNK = `PLUT_IDX_BANK << 2;
    localparam logic [7:0] A_DAT = `PLUT_IDX_DATA << 2;
    localparam logic [1:0] OK    = `PLUT_RESP_OKAY;
    localparam logic [1:0] ERR   = `PLUT_RESP_SLVERR;
    localparam int         LIM   = 64;

    logic        mclk;
    logic        rst_b;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic [7:0]  pixel;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [3:0]  red;
    logic [3:0]  green;
    logic [3:0]  blue;
    int          error_cnt;
    int          checks_done;

    plut_bank_regs u_dut (
        .mclk_i          (mclk),
        .rst_b_i         (rst_b),
        .s_axi_awaddr_i  (awaddr),
        .s_axi_awvalid_i (awvalid),
        .s_axi_awready_o (awready),
        .s_axi_wdata_i   (wdata),
        .s_axi_wstrb_i   (wstrb),
        .s_axi_wvalid_i  (wvalid),
        .s_axi_wready_o  (wready),
        .s_axi_bresp_o   (bresp),
        .s_axi_bvalid_o  (bvalid),
        .s_axi_bready_i  (bready),
        .s_axi_araddr_i  (araddr),
        .s_axi_arvalid_i (arvalid),
        .s_axi_arready_o (arready),
        .s_axi_rdata_o   (rdata),
        .s_axi_rresp_o   (rresp),
        .s_axi_rvalid_o  (rvalid),
        .s_axi_rready_i  (rready),
        .pixel_i         (pixel),
        .red_o           (red),
        .green_o         (green),
        .blue_o          (blue)
    );

    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;

    // Verdict in one place
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Value compare
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Response code compare
    task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // A hung handshake counts as a mismatch and ends the run
    task automatic hang();
        error_cnt++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < LIM; n++)
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (n == LIM)
            hang();
        chk_rsp(bresp, er);
        bready <= 1'b0;
    endtask

    // Read: rready raised after wt edges, then held until rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er, input int wt = 0);
        int n;
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= (wt == 0);
        for (n = 0; n < LIM; n++)
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
                break;
            if (n + 1 >= wt)
                rready <= 1'b1;
        end
        if (n == LIM)
            hang();
        chk_rsp(rresp, er);
        chk_val(rdata, ed);
        rready <= 1'b0;
    endtask

    // Table contents chosen so the sixteen entries of each colour all differ
    function automatic logic [3:0] tv(input int c, input int e);
        return 4'(e * 3 + c * 5 + 1);
    endfunction

    // Expected translated entry for one colour
    function automatic logic [3:0] xl(input int c, input logic [1:0] d,
                                      input logic [5:0] bk,
                                      input logic [7:0] p);
        logic [1:0] b;
        logic [3:0] e;
        b = 2'(bk >> (4 - 2 * c));
        case (d)
            2'h0: e = {1'b0, b, p[0]};
            2'h1: e = {b, p[1:0]};
            2'h2: e = p[3:0];
            default: e = (c == 0) ? {b[0], p[7:5]} :
                         (c == 1) ? {b[0], p[4:2]} : {b, p[1:0]};
        endcase
        return tv(c, int'(e));
    endfunction

    // Main sequence
    initial
    begin
        logic [5:0] bk;
        logic [7:0] p;
        mclk        = 1'b0;
        rst_b       = 1'b0;
        {awaddr, araddr, pixel, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        error_cnt   = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);

        // Reset state of registers and of red table entry 0
        rd(A_DEP, 32'h0, OK);
        rd(A_IDX, 32'h0, OK);
        rd(A_BNK, 32'h0, OK);
        rd(A_DAT, 32'h0, OK);
        $display("test reset done");

        // Fill all three tables with upper data bits set, read back
        for (int c = 0; c < 3; c++)
            for (int e = 0; e < 16; e++)
            begin
                wr(A_IDX, 32'(c * 16 + e), 4'hf, OK);
                wr(A_DAT, 32'hffff_fff0 | 32'(tv(c, e)), 4'hf, OK);
            end
        for (int c = 0; c < 3; c++)
            for (int e = 0; e < 16; e++)
            begin
                wr(A_IDX, 32'(c * 16 + e), 4'hf, OK);
                rd(A_DAT, 32'(tv(c, e)), OK);
            end
        $display("test tables done");

        // Colour code 3 and a dropped strobe leave tables untouched
        wr(A_IDX, 32'h35, 4'hf, OK);
        wr(A_DAT, 32'h9, 4'hf, OK);
        rd(A_DAT, 32'h0, OK);
        wr(A_IDX, 32'h0, 4'hf, OK);
        wr(A_DAT, 32'h0, 4'h0, OK);
        // Late rready: read data must stand until it is taken
        rd(A_DAT, 32'(tv(0, 0)), OK, 3);
        // Unmapped place answers with an error
        wr(8'h00, 32'hff, 4'hf, ERR);
        rd(8'h00, 32'h0, ERR);
        $display("test refusals done");

        // Translation for every depth, several banks and pixels
        for (int d = 0; d < 4; d++)
        begin
            wr(A_DEP, 32'(d), 4'hf, OK);
            rd(A_DEP, 32'(d), OK);
            for (int k = 0; k < 4; k++)
            begin
                bk = 6'(k * 27);
                wr(A_BNK, 32'(bk), 4'hf, OK);
                rd(A_BNK, 32'(bk), OK);
                for (int j = 0; j < 8; j++)
                begin
                    p = 8'(j * 53 + k);
                    @(posedge mclk);
                    pixel <= p;
                    @(posedge mclk);
                    #1;
                    chk_val(32'(red), 32'(xl(0, 2'(d), bk, p)));
                    chk_val(32'(green), 32'(xl(1, 2'(d), bk, p)));
                    chk_val(32'(blue), 32'(xl(2, 2'(d), bk, p)));
                end
            end
        end
        $display("test translation done");
        final_report();
    end

endmodule
